// ==== cswsu_checker.sv ====
// Port assertions for the chip-select unit.
`timescale 1ns/10ps
module cswsu_checker
#(parameter NUM_SEL = 10)
(
   input logic core_clk,
   input logic rst_n,
   input logic cycle_start,
   input logic cfg_write,
   input logic [3:0] cfg_index,
   input logic cfg_enable,
   input logic [NUM_SEL-1:0] select_n_reg,
   input logic cycle_done_reg,
   input logic cycle_busy_reg,
   input logic [NUM_SEL-1:0] cfg_enabled_reg
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   take_busy_a: assert property (cycle_start && !cycle_busy_reg |=> cycle_busy_reg)
      else $error("cycle not taken");
   idle_high_a: assert property (!cycle_busy_reg |-> &select_n_reg)
      else $error("select while idle");
   done_pulse_a: assert property (cycle_done_reg |=> !cycle_done_reg)
      else $error("done too long");
   done_end_a: assert property (cycle_done_reg |=> $fell(cycle_busy_reg))
      else $error("done without end");
   busy_fall_a: assert property ($fell(cycle_busy_reg) |-> $past(cycle_done_reg))
      else $error("end without done");
   sel_hold_a: assert property (cycle_busy_reg && $past(cycle_busy_reg) |-> $stable(select_n_reg))
      else $error("select moved");
   cfg_set_a: assert property (cfg_write && cfg_index < 10 |=>
      cfg_enabled_reg[$past(cfg_index)] == $past(cfg_enable)) else $error("enable lost");
   cfg_skip_a: assert property (cfg_write && cfg_index > 9 |=> $stable(cfg_enabled_reg))
      else $error("bad index written");
endmodule
bind cswsu_top cswsu_checker #(.NUM_SEL(NUM_SEL)) u_chk (.*);

// ==== cswsu_defs.vh ====
// Constants for the chip-select and wait-state unit.
`ifndef CSWSU_DEFS_VH
`define CSWSU_DEFS_VH
`define CSWSU_NUM_SEL 10
`define CSWSU_UPPER_IDX 9
`define CSWSU_FIELD_W 10
`define CSWSU_WAIT_W 4
`define CSWSU_MEM_ADDR_W 20
`define CSWSU_IO_ADDR_W 16
`define CSWSU_UPPER_START 10'h3ff
`define CSWSU_UPPER_STOP 10'h3ff
`define CSWSU_UPPER_WAIT 4'hf
`define CSWSU_PRB_W 8
`endif

// ==== cswsu_mem_model.sv ====
// Bus device model: ready after a chosen delay once selected.
`timescale 1ns/10ps
module cswsu_mem_model
(
   input logic core_clk,
   input logic [9:0] select_n,
   input logic [3:0] delay,
   output logic ext_ready
);
   logic [3:0] cnt_reg = 4'h0;
   always @(posedge core_clk)
      cnt_reg <= &select_n ? 4'h0 : cnt_reg + 4'h1;
   // Ready is pulled up while no device is selected.
   assign ext_ready = &select_n || cnt_reg >= delay;
endmodule

// ==== cswsu_top.v ====
// Chip-select and wait-state unit: ten windows, select outputs, wait and ready control.
`timescale 1ns/10ps
`include "cswsu_defs.vh"
// Contract
// - Ten selects, each memory or I/O space
// - Selects add waits and may end cycles
// - After reset only upper boot select, top 1K
// - Each select has start and stop setting
// - Ten-bit fields match top address bits
// - Memory 1K and I/O 64-byte granularity
// - Start above stop or disabled never selects
// - Wait count and ready-use bit per select
// - All matching overlapping selects assert together
// - Any ready user: least wait, then ready
// - All ignore ready: most wait, no ready
// - Selects stay off inside peripheral block
// - Refresh cycles are decoded like others
module cswsu_top
#(
   parameter NUM_SEL = `CSWSU_NUM_SEL,
   parameter FIELD_W = `CSWSU_FIELD_W,
   parameter WAIT_W = `CSWSU_WAIT_W
)
(
   input wire core_clk,
   input wire rst_n,
   input wire cycle_start,
   input wire cycle_is_io,
   input wire cycle_is_refresh,
   input wire [`CSWSU_MEM_ADDR_W-1:0] cycle_addr,
   input wire ext_ready,
   input wire [`CSWSU_MEM_ADDR_W-1:0] prb_base,
   input wire prb_in_io,
   input wire cfg_write,
   input wire [3:0] cfg_index,
   input wire cfg_enable,
   input wire cfg_io_space,
   input wire cfg_use_ready,
   input wire [WAIT_W-1:0] cfg_wait,
   input wire [FIELD_W-1:0] cfg_start,
   input wire [FIELD_W-1:0] cfg_stop,
   output reg [NUM_SEL-1:0] select_n_reg,
   output reg cycle_done_reg,
   output reg cycle_busy_reg,
   output reg [NUM_SEL-1:0] cfg_enabled_reg
);
   localparam ST_IDLE = 2'd0;
   localparam ST_WAIT = 2'd1;
   localparam ST_READY = 2'd2;
   localparam ST_DONE = 2'd3;

   // **************************************************
   // Configuration storage
   // **************************************************
   reg [NUM_SEL-1:0] io_space_reg;
   reg [NUM_SEL-1:0] use_ready_reg;
   reg [WAIT_W-1:0] wait_reg [0:NUM_SEL-1];
   reg [FIELD_W-1:0] start_reg [0:NUM_SEL-1];
   reg [FIELD_W-1:0] stop_reg [0:NUM_SEL-1];
   wire [NUM_SEL-1:0] hit;
   wire [FIELD_W-1:0] mem_field;
   wire [FIELD_W-1:0] io_field;
   wire [FIELD_W-1:0] cycle_field;
   wire in_prb;
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [WAIT_W-1:0] count_reg;
   reg [WAIT_W-1:0] count_next;
   reg [WAIT_W-1:0] min_wait;
   reg [WAIT_W-1:0] max_wait;
   reg any_ready;
   reg any_hit;
   reg [NUM_SEL-1:0] select_n_next;
   integer i;
   integer j;

   // Memory compares A19:10 (1K steps), I/O compares A15:6 (64-byte steps).
   assign mem_field = cycle_addr[19:10];
   assign io_field = cycle_addr[15:6];
   assign cycle_field = cycle_is_io ? io_field : mem_field;
   // The peripheral block is the 256 bytes that share its base's bits above A7, in its chosen space.
   assign in_prb = (prb_in_io == cycle_is_io) &&
      (cycle_is_io ? (cycle_addr[15:8] == prb_base[15:8])
                   : (cycle_addr[19:8] == prb_base[19:8]));

   genvar g;
   generate
      for (g = 0; g < NUM_SEL; g = g + 1)
      begin : gen_win
         cswsu_window #(.FIELD_W(FIELD_W)) u_win
         (
            .cycle_field(cycle_field),
            .cycle_is_io(cycle_is_io),
            .in_prb(in_prb),
            .enable(cfg_enabled_reg[g]),
            .io_space(io_space_reg[g]),
            .start_field(start_reg[g]),
            .stop_field(stop_reg[g]),
            .hit(hit[g])
         );
      end
   endgenerate

   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_enabled_reg <= {{(NUM_SEL-1){1'b0}}, 1'b1} << `CSWSU_UPPER_IDX;
         io_space_reg <= {NUM_SEL{1'b0}};
         use_ready_reg <= {NUM_SEL{1'b0}};
         for (i = 0; i < NUM_SEL; i = i + 1)
         begin
            wait_reg[i] <= `CSWSU_UPPER_WAIT;
            start_reg[i] <= `CSWSU_UPPER_START;
            stop_reg[i] <= `CSWSU_UPPER_STOP;
         end
      end
      else if (cfg_write && (cfg_index < NUM_SEL))
      begin
         cfg_enabled_reg[cfg_index] <= cfg_enable;
         io_space_reg[cfg_index] <= cfg_io_space;
         use_ready_reg[cfg_index] <= cfg_use_ready;
         wait_reg[cfg_index] <= cfg_wait;
         start_reg[cfg_index] <= cfg_start;
         stop_reg[cfg_index] <= cfg_stop;
      end
   end

   // **************************************************
   // Wait selection over the overlapping hits
   // **************************************************
   always @*
   begin
      min_wait = {WAIT_W{1'b1}};
      max_wait = {WAIT_W{1'b0}};
      any_ready = 1'b0;
      any_hit = 1'b0;
      // The least count is taken over every overlapping window, not only the ready users.
      for (j = 0; j < NUM_SEL; j = j + 1)
      begin
         if (hit[j])
         begin
            any_hit = 1'b1;
            if (use_ready_reg[j])
               any_ready = 1'b1;
            if (wait_reg[j] < min_wait)
               min_wait = wait_reg[j];
            if (wait_reg[j] > max_wait)
               max_wait = wait_reg[j];
         end
      end
   end

   // **************************************************
   // Bus cycle sequencer
   // **************************************************
   reg honour_reg;
   reg honour_next;
   always @*
   begin
      state_next = state_reg;
      count_next = count_reg;
      honour_next = honour_reg;
      select_n_next = select_n_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (cycle_start)
            begin
               // Refresh cycles decode exactly like any other cycle.
               select_n_next = ~hit;
               honour_next = any_ready || !any_hit;
               count_next = any_ready ? min_wait : (any_hit ? max_wait : {WAIT_W{1'b0}});
               state_next = ST_WAIT;
            end
         end
         ST_WAIT:
         begin
            if (count_reg != {WAIT_W{1'b0}})
               count_next = count_reg - {{(WAIT_W-1){1'b0}}, 1'b1};
            else if (honour_reg)
            begin
               // Ready is first sampled once the last wait clock has passed.
               if (ext_ready)
                  state_next = ST_DONE;
               else
                  state_next = ST_READY;
            end
            else
               state_next = ST_DONE;
         end
         ST_READY:
         begin
            if (ext_ready)
               state_next = ST_DONE;
         end
         ST_DONE:
         begin
            select_n_next = {NUM_SEL{1'b1}};
            state_next = ST_IDLE;
         end
         default:
            state_next = ST_IDLE;
      endcase
   end

   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= ST_IDLE;
         count_reg <= {WAIT_W{1'b0}};
         honour_reg <= 1'b0;
         select_n_reg <= {NUM_SEL{1'b1}};
         cycle_done_reg <= 1'b0;
         cycle_busy_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         count_reg <= count_next;
         honour_reg <= honour_next;
         select_n_reg <= select_n_next;
         cycle_done_reg <= (state_next == ST_DONE);
         cycle_busy_reg <= (state_next != ST_IDLE);
      end
   end
endmodule

// ==== cswsu_top_test.sv ====
// Self-checking bench for the chip-select unit.
`timescale 1ns/10ps
module cswsu_top_test;
   logic core_clk = 0, rst_n = 0, cycle_start = 0, cycle_is_io = 0, cycle_is_refresh = 0;
   logic prb_in_io = 0, cfg_write = 0, cfg_enable = 0, cfg_io_space = 0, cfg_use_ready = 0;
   logic [19:0] cycle_addr = 0, prb_base = 0;
   logic [3:0] cfg_index = 0, cfg_wait = 0, delay = 0, wt[10];
   logic [9:0] cfg_start = 0, cfg_stop = 0, select_n_reg, cfg_enabled_reg, st[10], sp[10], t, f;
   logic cycle_done_reg, cycle_busy_reg, ext_ready, u, en[10], io[10], ur[10];
   int errors = 0, cmp_count = 0, lat, w, i, j, n;
   always #12.5 core_clk = ~core_clk;
   cswsu_top u_dut (.*);
   cswsu_mem_model u_mem (.core_clk, .select_n(select_n_reg), .delay, .ext_ready);
   task automatic check(string s, logic [9:0] v, logic [9:0] e);
      cmp_count++;
      if (v !== e)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", s, e, v);
      end
   endtask
   task automatic results;
      $display("compares %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic cfg(int k, logic [26:0] c);
      @(negedge core_clk);
      {cfg_write, cfg_index} = {1'b1, 4'(k)};
      {cfg_enable, cfg_io_space, cfg_use_ready, cfg_wait, cfg_start, cfg_stop} = c;
      if (k < 10) {en[k], io[k], ur[k], wt[k], st[k], sp[k]} = c;
      @(negedge core_clk) cfg_write = 0;
   endtask
   function automatic logic [9:0] hits(logic [19:0] a, logic o);
      f = o ? a[15:6] : a[19:10];
      for (int k = 0; k < 10; k++)
         hits[k] = en[k] && io[k] == o && st[k] <= f && f <= sp[k] &&
            !(o == prb_in_io && a[19:8] == prb_base[19:8]);
   endfunction
   task automatic run(logic [19:0] a, logic o);
      logic [9:0] h;
      h = hits(a, o);
      u = h == 0;
      for (j = 0; j < 10; j++) u |= h[j] & ur[j];
      w = u && h != 0 ? 15 : 0;
      for (j = 0; j < 10; j++)
         if (h[j] && (u ? wt[j] < w : wt[j] > w)) w = wt[j];
      @(negedge core_clk);
      {cycle_start, cycle_addr, cycle_is_io, cycle_is_refresh} = {1'b1, a, o, 1'($urandom)};
      @(negedge core_clk) cycle_start = 0;
      @(negedge core_clk) check("select", select_n_reg, ~h);
      for (lat = 2; !cycle_done_reg && lat < 60; lat++) @(negedge core_clk);
      if (lat == 60)
      begin
         errors++;
         results;
      end
      else
      begin
         if (u && h != 0 && delay > w) w = delay;
         check("wait", lat, w + 2);
      end
   endtask
   initial
   begin
      void'($urandom(32'h38386d11));
      for (i = 0; i < 10; i++) {en[i], io[i], ur[i], wt[i], st[i], sp[i]} = {i == 9, 26'hfffff};
      for (i = 0; i < 10; i++) wt[i] = 4'hf;
      repeat (4) @(negedge core_clk);
      rst_n = 1;
      check("enabled", cfg_enabled_reg, 10'h200);
      run(20'hffc00, 0);
      run(20'hfffff, 0);
      run(20'hffbff, 0);
      run(20'h0fffc, 1);
      prb_base = {4'h0, 16'($urandom)};
      prb_in_io = 1'($urandom);
      cfg(12, 27'h1003ff);
      check("ignored", cfg_enabled_reg, 10'h200);
      for (i = 0; i < 150; i++)
      begin
         n = $urandom % 10;
         t = i % 3 ? 10'($urandom) : st[n];
         cfg(i % 10, {$urandom % 4 != 0, 6'($urandom), t,
            i % 3 ? t + 10'($urandom % 48) : sp[n]});
         delay = $urandom % 2 ? 4'($urandom) : 4'h0;
         t = st[n] + 10'($urandom % 4);
         if (i % 7 == 0) run({prb_base[19:8], 8'($urandom)}, prb_in_io);
         else if (io[n]) run({4'h0, t, 6'($urandom)}, 1);
         else run({t, 10'($urandom)}, 0);
      end
      results;
   end
endmodule

// ==== cswsu_window.v ====
// One select window comparator with its own start and stop configuration.
`timescale 1ns/10ps
`include "cswsu_defs.vh"
module cswsu_window
#(
   parameter FIELD_W = 10
)
(
   input wire [FIELD_W-1:0] cycle_field,
   input wire cycle_is_io,
   input wire in_prb,
   input wire enable,
   input wire io_space,
   input wire [FIELD_W-1:0] start_field,
   input wire [FIELD_W-1:0] stop_field,
   output wire hit
);
   // **************************************************
   // Window compare
   // **************************************************
   wire in_range;
   assign in_range = (cycle_field >= start_field) && (cycle_field <= stop_field);
   assign hit = enable && (io_space == cycle_is_io) && in_range && !in_prb;
endmodule
